// file: design/blcm_consts.vh
// constants, register map and timing for the buck load current measurement block
`ifndef BLCM_CONSTS_VH
`define BLCM_CONSTS_VH

// register offsets
`define BLCM_A_SEL      8'h00
`define BLCM_A_LOAD1    8'h01
`define BLCM_A_LOAD2    8'h02
`define BLCM_A_STAT     8'h03
`define BLCM_A_CLR      8'h04
`define BLCM_A_EN       8'h05
`define BLCM_A_MASK     8'h06
`define BLCM_A_CFG      8'h07
`define BLCM_A_MODE     8'h08

// field positions
`define BLCM_B_SEL      0
`define BLCM_B_DONE     0
`define BLCM_B_FPWM0    0
`define BLCM_B_FPWM1    1
`define BLCM_B_BUSY     2

// reset values
`define BLCM_RST_MASK   1'b0
`define BLCM_RST_EN     1'b1
`define BLCM_RST_FPWM   2'b00

// timing
`define BLCM_SEQ_US     50
`define BLCM_CLK_MHZ    250
`define BLCM_SEQ_CYC    (`BLCM_SEQ_US * `BLCM_CLK_MHZ)

// load scaling
`define BLCM_LSB_MA     20
`define BLCM_PWM_MA     520
`define BLCM_PWM_CODE   (`BLCM_PWM_MA / `BLCM_LSB_MA)

`endif

// file: design/blcm_mode_sel.v
// pwm/pfm mode selection for one buck converter
`timescale 1ns/1ns
`default_nettype none
`include "blcm_consts.vh"
module blcm_mode_sel #(
	parameter W = 9
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         force_pwm,
	input  wire         meas_force,
	input  wire [W-1:0] load_code,
	output reg          pwm_mode
);
	localparam integer PWM_INT  = `BLCM_PWM_CODE;
	localparam [W-1:0] PWM_CODE = PWM_INT[W-1:0];
	wire pwm_nxt;

	// forced modes win; otherwise load decides, at or above threshold runs pwm
	assign pwm_nxt = force_pwm | meas_force | (load_code >= PWM_CODE);

	// registered so the power stage sees a clean level
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_mode <= 1'b1;
		end else begin
			pwm_mode <= pwm_nxt;
		end
	end
endmodule
`default_nettype wire

// file: design/blcm_top.v
// buck load current measurement controller with register port and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "blcm_consts.vh"
module blcm_top #(
	parameter W        = 9,
	parameter SEQ_CYC  = `BLCM_SEQ_CYC,
	parameter SAMP_CYC = 16
) (
	input  wire         MCLK,
	input  wire         RST_N,
	input  wire [7:0]   ADDR,
	input  wire [7:0]   WDATA,
	input  wire         WR,
	input  wire         RD,
	output reg  [7:0]   RDATA,
	input  wire [W-1:0] ADC_B0,
	input  wire [W-1:0] ADC_B1,
	output wire         ADC_SEL,
	output wire         PWM_B0,
	output wire         PWM_B1,
	output wire         BUSY,
	output wire         HOST_IRQ_N
);
	//////////////////////////////////////////////////////////////////////////
	// state and registers
	localparam IDLE = 1'b0;
	localparam MEAS = 1'b1;
	localparam CW = 16;
	// integer forms first so the cut to the counter width is deliberate
	localparam integer  SEQ_END   = SEQ_CYC - 1;
	localparam integer  SAMP_END  = SAMP_CYC - 1;
	localparam [CW-1:0] SEQ_LAST  = SEQ_END[CW-1:0];
	localparam [CW-1:0] SAMP_LAST = SAMP_END[CW-1:0];

	reg          state_r;
	reg          state_nxt;
	reg [CW-1:0] cnt_r;
	reg [CW-1:0] cnt_nxt;
	reg          sel_r;
	reg [W+3:0]  acc_r;
	reg [W+3:0]  acc_nxt;
	reg [W-1:0]  result_r;
	reg [W-1:0]  result_nxt;
	reg          measure_done_flag_r;
	reg          done_en_r;
	reg          measure_done_mask_r;
	reg [1:0]    fpwm_r;
	wire         wr_sel;
	wire         wr_clr;
	wire         done_pulse;
	wire [W-1:0] adc_mux;
	wire         pwm0;
	wire         pwm1;
	wire [1:0]   pwm_vec;

	assign wr_sel  = WR && (ADDR == `BLCM_A_SEL);
	assign wr_clr  = WR && (ADDR == `BLCM_A_CLR);
	assign adc_mux = sel_r ? ADC_B1 : ADC_B0;
	assign ADC_SEL = sel_r;
	assign BUSY    = (state_r == MEAS);
	assign done_pulse = (state_r == MEAS) && (cnt_r == SEQ_LAST) && !wr_sel;

	//////////////////////////////////////////////////////////////////////////
	// measurement sequencer: averages SAMP_CYC samples, ends at SEQ_CYC cycles
	always @* begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		acc_nxt    = acc_r;
		result_nxt = result_r;
		if (wr_sel) begin
			// a new write restarts even a running sequence
			state_nxt = MEAS;
			cnt_nxt   = {CW{1'b0}};
			acc_nxt   = {(W+4){1'b0}};
		end else if (state_r == MEAS) begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r <= SAMP_LAST) begin
				acc_nxt = acc_r + {4'h0, adc_mux};
			end
			if (cnt_r == SEQ_LAST) begin
				// fixed end count bounds the sequence length
				state_nxt  = IDLE;
				result_nxt = acc_r[W+3:4];
			end
		end
	end

	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r  <= IDLE;
			cnt_r    <= {CW{1'b0}};
			acc_r    <= {(W+4){1'b0}};
			result_r <= {W{1'b0}};
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			acc_r    <= acc_nxt;
			result_r <= result_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// register writes
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_r               <= 1'b0;
			done_en_r           <= `BLCM_RST_EN;
			measure_done_mask_r <= `BLCM_RST_MASK;
			fpwm_r              <= `BLCM_RST_FPWM;
		end else if (WR) begin
			if (ADDR == `BLCM_A_SEL) begin
				sel_r <= WDATA[`BLCM_B_SEL];
			end else if (ADDR == `BLCM_A_EN) begin
				done_en_r <= WDATA[`BLCM_B_DONE];
			end else if (ADDR == `BLCM_A_MASK) begin
				measure_done_mask_r <= WDATA[`BLCM_B_DONE];
			end else if (ADDR == `BLCM_A_CFG) begin
				fpwm_r <= WDATA[`BLCM_B_FPWM1:`BLCM_B_FPWM0];
			end
		end
	end

	// sticky flag; a set in the clear cycle wins
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			measure_done_flag_r <= 1'b0;
		end else if (done_pulse && done_en_r) begin
			measure_done_flag_r <= 1'b1;
		end else if (wr_clr && WDATA[`BLCM_B_DONE]) begin
			measure_done_flag_r <= 1'b0;
		end
	end

	// mask set blocks the line, flag stays visible in status
	assign HOST_IRQ_N = ~(measure_done_flag_r & ~measure_done_mask_r);

	//////////////////////////////////////////////////////////////////////////
	// register reads, one cycle latency; unmapped reads give zero
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			if (ADDR == `BLCM_A_SEL) begin
				RDATA <= {7'h00, sel_r};
			end else if (ADDR == `BLCM_A_LOAD1) begin
				RDATA <= result_r[7:0];
			end else if (ADDR == `BLCM_A_LOAD2) begin
				RDATA <= {7'h00, result_r[W-1]};
			end else if (ADDR == `BLCM_A_STAT) begin
				RDATA <= {7'h00, measure_done_flag_r};
			end else if (ADDR == `BLCM_A_EN) begin
				RDATA <= {7'h00, done_en_r};
			end else if (ADDR == `BLCM_A_MASK) begin
				RDATA <= {7'h00, measure_done_mask_r};
			end else if (ADDR == `BLCM_A_CFG) begin
				RDATA <= {6'h00, fpwm_r};
			end else if (ADDR == `BLCM_A_MODE) begin
				RDATA <= {5'h00, BUSY, pwm1, pwm0};
			end else begin
				RDATA <= 8'h00;
			end
		end else begin
			RDATA <= 8'h00;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// mode selection per converter
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_mode
			blcm_mode_sel #(.W(W)) u_mode (
				.clk        (MCLK),
				.rst_n      (RST_N),
				.force_pwm  (fpwm_r[g]),
				.meas_force (BUSY && (sel_r == g)),
				.load_code  (g == 0 ? ADC_B0 : ADC_B1),
				.pwm_mode   (pwm_vec[g])
			);
		end
	endgenerate
	assign pwm0   = pwm_vec[0];
	assign pwm1   = pwm_vec[1];
	assign PWM_B0 = pwm0;
	assign PWM_B1 = pwm1;
endmodule
`default_nettype wire

// file: verif/blcm_load_model.sv
// load current source standing in for both converters' sense paths
`timescale 1ns/1ns
`default_nettype none
module blcm_load_model (
	input  var int     ma0,
	input  var int     ma1,
	output logic [8:0] code0,
	output logic [8:0] code1
);
	// one count per 20 ma; clamp keeps the code inside 9 bits
	assign code0 = (ma0 > 10220) ? 9'h1ff : 9'(ma0 / 20);
	assign code1 = (ma1 > 10220) ? 9'h1ff : 9'(ma1 / 20);
endmodule
`default_nettype wire

// file: verif/blcm_properties.sv
// port assertions for the measurement controller
`timescale 1ns/1ns
`default_nettype none
module blcm_props #(
	parameter W = 9,
	parameter SEQ_CYC = 40
) (
	input wire         MCLK,
	input wire         RST_N,
	input wire [7:0]   ADDR,
	input wire [7:0]   WDATA,
	input wire         WR,
	input wire         RD,
	input wire [7:0]   RDATA,
	input wire [W-1:0] ADC_B0,
	input wire [W-1:0] ADC_B1,
	input wire         ADC_SEL,
	input wire         PWM_B0,
	input wire         PWM_B1,
	input wire         BUSY,
	input wire         HOST_IRQ_N
);
	logic [15:0] cnt_r;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// busy cycles since the last start; a restart zeroes it
	always @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) cnt_r <= 16'h0;
		else if (WR && ADDR == 8'h00) cnt_r <= 16'h0;
		else if (BUSY) cnt_r <= cnt_r + 16'h1;
	end
	chk_sel_start: assert property (WR && ADDR == 8'h00 |=> BUSY)
		else $error("no start");
	chk_sel_buck: assert property (WR && ADDR == 8'h00 |=> ADC_SEL == $past(WDATA[0]))
		else $error("wrong buck");
	chk_busy_len: assert property (BUSY |-> cnt_r < 16'(SEQ_CYC))
		else $error("too long");
	chk_done_time: assert property ($fell(BUSY) |-> cnt_r == 16'(SEQ_CYC))
		else $error("end early");
	chk_pwm_forced: assert property (BUSY && $past(BUSY) && $stable(ADC_SEL)
		|-> (ADC_SEL ? PWM_B1 : PWM_B0)) else $error("not pwm");
	chk_irq_cause: assert property ($fell(HOST_IRQ_N)
		|-> $fell(BUSY) || $past(WR && ADDR == 8'h06)) else $error("irq");
	chk_irq_clear: assert property (WR && ADDR == 8'h04 && WDATA[0]
		|=> HOST_IRQ_N || $fell(BUSY)) else $error("no clear");
	chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("rdata");
	chk_auto_mode: assert property (!PWM_B0 |-> $past(ADC_B0) < 9'h1a)
		else $error("pfm");
endmodule
bind blcm_top blcm_props #(.W(W), .SEQ_CYC(SEQ_CYC)) u_blcm_props (.*);
`default_nettype wire

// file: verif/blcm_top_test.sv
// self-checking bench for the measurement controller
`timescale 1ns/1ns
`default_nettype none
module blcm_top_test;
	logic       MCLK = 0, RST_N = 0, WR = 0, RD = 0;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00;
	wire  [7:0] RDATA;
	wire  [8:0] ADC_B0, ADC_B1;
	wire        ADC_SEL, PWM_B0, PWM_B1, BUSY, HOST_IRQ_N;
	int         ma0 = 0, ma1 = 0, fail_count = 0, n_checks = 0, cyc = 0;
	blcm_top #(.SEQ_CYC(40)) u_blcm_top (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ADC_B0(ADC_B0),
		.ADC_B1(ADC_B1), .ADC_SEL(ADC_SEL), .PWM_B0(PWM_B0), .PWM_B1(PWM_B1),
		.BUSY(BUSY), .HOST_IRQ_N(HOST_IRQ_N));
	blcm_load_model u_blcm_load_model (.ma0(ma0), .ma1(ma1), .code0(ADC_B0), .code1(ADC_B1));
	initial forever #2 MCLK = ~MCLK;
	////////////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		{ADDR, WDATA, WR} <= {a, d, 1'b1};
		@(posedge MCLK);
		WR <= 0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge MCLK);
		{ADDR, RD} <= {a, 1'b1};
		@(posedge MCLK);
		RD <= 0;
		#1 check(RDATA, exp);
	endtask
	// start a measurement and time it; the chosen buck must switch in pwm
	task meas(input logic s);
		int n;
		wr(8'h00, {7'h0, s});
		check(BUSY, 1);
		check(ADC_SEL, s);
		for (n = 0; BUSY === 1 && n < 100; n++) begin
			@(posedge MCLK);
			#1 if (n == 1) check(s ? PWM_B1 : PWM_B0, 1);
		end
		check(n, 40);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// run-away guard well past the expected few hundred cycles
	always @(posedge MCLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count++;
			finish_test;
		end
	end
	initial begin
		repeat (20) @(posedge MCLK);
		RST_N <= 1;
		rd(8'h05, 1); rd(8'h06, 0); rd(8'h07, 0); rd(8'h20, 0);
		ma0 <= 6000; ma1 <= 200;
		meas(0);
		check(HOST_IRQ_N, 0);
		rd(8'h01, 8'h2c); rd(8'h02, 1); rd(8'h03, 1);
		wr(8'h04, 1);
		check(HOST_IRQ_N, 1);
		wr(8'h06, 1);
		meas(1);
		check(HOST_IRQ_N, 1);
		rd(8'h01, 8'h0a); rd(8'h02, 0); rd(8'h03, 1);
		wr(8'h06, 0);
		check(HOST_IRQ_N, 0);
		wr(8'h04, 1); wr(8'h05, 0);
		// mid-sequence read must still show the old result; the next write restarts
		wr(8'h00, 8'h00);
		rd(8'h01, 8'h0a);
		meas(0);
		rd(8'h03, 0);
		rd(8'h01, 8'h2c);
		ma0 <= 200;
		repeat (3) @(posedge MCLK);
		#1 check(PWM_B0, 0);
		wr(8'h07, 1);
		repeat (2) @(posedge MCLK);
		#1 check(PWM_B0, 1);
		ma0 <= 600; wr(8'h07, 0);
		rd(8'h08, 1);
		finish_test;
	end
endmodule
`default_nettype wire
